/* File: rtl/rsc_calc.sv */
// room setpoint calculator with an ahb-lite register slave
// assumes local controls and scene/program strobes come from logic on hclk
// Operation
// RL1: heating: base plus offset, reduced, or frost
// RL2: cooling: add dead zone and mode increases
// RL3: cooling protection uses heat protection setpoint
// RL4: offset always relative to base, replaces previous
// RL5: offset clamped to plus minus maximum
// RL6: offset source follows rotary control function
// RL7: bus base write only in offset function
// RL8: base survives bus supply reset
// RL9: base clamped to min and max
// RL10: final setpoint clamped to protection limits
// RL11: heat/cool chosen automatically or by object
// RL12: mode from operator, object, program, scene
// RL13: base is comfort and reduction reference
// RL14: all temperatures signed 0.1 K fixed point
`timescale 1ns/1ps
module rsc_calc (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                por_n,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire rsc_pkg::rsc_local_t local_in,
    input  wire logic                scene_stb,
    input  wire rsc_pkg::rsc_mode_t  scene_mode,
    input  wire logic                prog_stb,
    input  wire rsc_pkg::rsc_mode_t  prog_mode,
    input  wire rsc_pkg::rsc_temp_t  room_temp,
    output rsc_pkg::rsc_temp_t       setpoint,
    output logic                     cooling,
    output rsc_pkg::rsc_mode_t       active_mode
);

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    logic       wr_q;
    logic [7:0] wa_q;
    wire        acc   = hsel & htrans[1] & hready;
    wire        wr_en = wr_q;
    wire [15:0] wd    = hwdata[15:0];


    // ------------------------------------------------------------
    // bus response: zero wait, always okay
    // ------------------------------------------------------------

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;


    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
        end else begin
            wr_q <= acc & hwrite;
            wa_q <= haddr[7:0];
        end
    end

    // ------------------------------------------------------------
    // write decode in the data phase
    // ------------------------------------------------------------

    wire w_ctrl  = wr_en && wa_q == rsc_pkg::OFS_CTRL;
    wire w_base  = wr_en && wa_q == rsc_pkg::OFS_BASE;
    wire w_off   = wr_en && wa_q == rsc_pkg::OFS_OFFSET;
    wire w_mode  = wr_en && wa_q == rsc_pkg::OFS_MODE;
    wire w_cfg   = wr_en && wa_q >= rsc_pkg::OFS_MAX_OFF && wa_q <= rsc_pkg::OFS_HEAT_SP;


    // ------------------------------------------------------------
    // control and configuration registers
    // ------------------------------------------------------------
    logic [2:0]         ctrl_q;
    rsc_pkg::rsc_cfg_t  cfg_q;
    rsc_pkg::rsc_temp_t cfg_arr [9];


    wire rot_is_off = ctrl_q[rsc_pkg::CTRL_ROT_OFFSET];
    wire hc_auto    = ctrl_q[rsc_pkg::CTRL_HC_AUTO];
    wire hc_obj     = ctrl_q[rsc_pkg::CTRL_HC_COOL];


    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= rsc_pkg::RST_CTRL;
        end else if (w_ctrl) begin
            ctrl_q <= hwdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // configuration words
    // ------------------------------------------------------------

    // word index 0..8 of the configuration block
    wire [3:0] cfg_idx = 4'((wa_q - rsc_pkg::OFS_MAX_OFF) >> 2);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= '{rsc_pkg::RST_MAX_OFF, rsc_pkg::RST_BASE_MIN, rsc_pkg::RST_BASE_MAX,
                       rsc_pkg::RST_STBY_RED, rsc_pkg::RST_DEAD_ZONE, rsc_pkg::RST_STBY_INC,
                       rsc_pkg::RST_NIGHT_INC, rsc_pkg::RST_FROST_SP, rsc_pkg::RST_HEAT_SP};
        end else if (w_cfg) begin
            unique case (cfg_idx)
                4'h0:    cfg_q.max_off   <= wd;
                4'h1:    cfg_q.base_min  <= wd;
                4'h2:    cfg_q.base_max  <= wd;
                4'h3:    cfg_q.stby_red  <= wd;
                4'h4:    cfg_q.dead_zone <= wd;
                4'h5:    cfg_q.stby_inc  <= wd;
                4'h6:    cfg_q.night_inc <= wd;
                4'h7:    cfg_q.frost_sp  <= wd;
                default: cfg_q.heat_sp   <= wd;
            endcase
        end
    end


    // indexed view of the configuration for reads

    assign cfg_arr[0] = cfg_q.max_off;
    assign cfg_arr[1] = cfg_q.base_min;
    assign cfg_arr[2] = cfg_q.base_max;
    assign cfg_arr[3] = cfg_q.stby_red;
    assign cfg_arr[4] = cfg_q.dead_zone;
    assign cfg_arr[5] = cfg_q.stby_inc;
    assign cfg_arr[6] = cfg_q.night_inc;
    assign cfg_arr[7] = cfg_q.frost_sp;
    assign cfg_arr[8] = cfg_q.heat_sp;

    // ------------------------------------------------------------
    // base setpoint and offset sources
    // ------------------------------------------------------------
    // a bus write to base counts only in offset function  see RL7
    wire bus_base = w_base & rot_is_off;
    // rotary sets base when not used as offset  see RL6
    wire rot_base = local_in.rot_stb & ~rot_is_off;
    wire rot_off  = local_in.rot_stb & rot_is_off;
    wire bus_off  = w_off & ~rot_is_off;


    // clamps of incoming base and offset

    rsc_pkg::rsc_temp_t base_in;
    rsc_pkg::rsc_temp_t base_cl;
    rsc_pkg::rsc_temp_t off_in;
    rsc_pkg::rsc_temp_t off_cl;
    rsc_pkg::rsc_temp_t off_lim_n;

    // base from the selected source
    assign base_in = rot_base ? local_in.rot_val : wd;
    // incoming base limited to its valid window  see RL9
    assign base_cl = (base_in < cfg_q.base_min) ? cfg_q.base_min :
                     (base_in > cfg_q.base_max) ? cfg_q.base_max : base_in;

    // offset from the selected source
    assign off_in    = rot_off ? local_in.rot_val : wd;
    // negative limit of the offset window
    assign off_lim_n = -cfg_q.max_off;
    // symmetric offset window  see RL5
    assign off_cl = (off_in > cfg_q.max_off) ? cfg_q.max_off :
                    (off_in < off_lim_n)     ? off_lim_n     : off_in;

    // ------------------------------------------------------------
    // base register
    // ------------------------------------------------------------

    // base survives the bus-supply reset, only power-on reloads RST_BASE  see RL8
    rsc_pkg::rsc_temp_t base_q;
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            base_q <= rsc_pkg::RST_BASE;
        end else if (rot_base || bus_base) begin
            base_q <= base_cl;
        end
    end

    // ------------------------------------------------------------
    // offset register
    // ------------------------------------------------------------

    // each new offset replaces the previous one  see RL4
    rsc_pkg::rsc_temp_t off_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            off_q <= '0;
        end else if (rot_off || bus_off) begin
            off_q <= off_cl;
        end
    end

    // ------------------------------------------------------------
    // operating mode, last instruction wins
    // ------------------------------------------------------------
    rsc_pkg::rsc_mode_t mode_q;
    rsc_pkg::rsc_mode_t mode_d;


    // bus object beats operator, program and scene in the same cycle
    assign mode_d = w_mode             ? rsc_pkg::rsc_mode_t'(hwdata[1:0]) :
                    local_in.mode_stb  ? local_in.mode_val :
                    prog_stb           ? prog_mode :
                    scene_stb          ? scene_mode : mode_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= rsc_pkg::MODE_COMFORT;
        end else begin
            mode_q <= mode_d;  // see RL12
        end
    end

    // ------------------------------------------------------------
    // heating / cooling selection
    // ------------------------------------------------------------
    // two guard bits keep sums of four terms from wrapping
    localparam int XW = rsc_pkg::TW + 2;
    typedef logic signed [XW-1:0] ext_t;

    ext_t comfort;
    ext_t cool_on;
    logic cool_q;
    logic cool_d;


    // comfort and cooling thresholds

    // base is the comfort reference  see RL13
    assign comfort = ext_t'(base_q) + ext_t'(off_q);
    assign cool_on = comfort + ext_t'(cfg_q.dead_zone);


    // automatic switching holds inside the dead zone  see RL11
    assign cool_d = !hc_auto                      ? hc_obj :
                    ext_t'(room_temp) > cool_on   ? 1'b1   :
                    ext_t'(room_temp) < comfort   ? 1'b0   : cool_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cool_q <= 1'b0;
        end else begin
            cool_q <= cool_d;
        end
    end

    // ------------------------------------------------------------
    // setpoint calculation in extended signed width  see RL14
    // ------------------------------------------------------------
    ext_t heat_sp;
    ext_t cool_sp;
    ext_t raw_sp;
    ext_t fin_sp;

    // heating: night uses the standby reduction as well  see RL1
    assign heat_sp = (mode_q == rsc_pkg::MODE_COMFORT) ? comfort :
                     (mode_q == rsc_pkg::MODE_PROTECT) ? ext_t'(cfg_q.frost_sp) :
                     comfort - ext_t'(cfg_q.stby_red);

    // cooling: dead zone plus mode increase  see RL2
    // protection replaces the whole sum  see RL3
    assign cool_sp = (mode_q == rsc_pkg::MODE_COMFORT) ? cool_on :
                     (mode_q == rsc_pkg::MODE_STANDBY) ? cool_on + ext_t'(cfg_q.stby_inc) :
                     (mode_q == rsc_pkg::MODE_NIGHT)   ? cool_on + ext_t'(cfg_q.night_inc) :
                     ext_t'(cfg_q.heat_sp);


    // path chosen by the registered heat/cool state
    assign raw_sp = cool_q ? cool_sp : heat_sp;


    // safety limits from frost and heat protection  see RL10
    assign fin_sp = (raw_sp < ext_t'(cfg_q.frost_sp)) ? ext_t'(cfg_q.frost_sp) :
                    (raw_sp > ext_t'(cfg_q.heat_sp))  ? ext_t'(cfg_q.heat_sp)  : raw_sp;

    // ------------------------------------------------------------
    // setpoint output register
    // ------------------------------------------------------------

    rsc_pkg::rsc_temp_t sp_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_q <= rsc_pkg::RST_BASE;
        end else begin
            sp_q <= rsc_pkg::rsc_temp_t'(fin_sp);
        end
    end


    // outputs

    assign setpoint    = sp_q;
    assign cooling     = cool_q;
    assign active_mode = mode_q;

    // ------------------------------------------------------------
    // read data, registered during the address phase
    // ------------------------------------------------------------
    // read decode on the live address phase
    wire [7:0]  ra      = haddr[7:0];
    wire [3:0]  r_idx   = 4'((ra - rsc_pkg::OFS_MAX_OFF) >> 2);
    wire        r_cfg   = ra >= rsc_pkg::OFS_MAX_OFF && ra <= rsc_pkg::OFS_HEAT_SP;
    // status: mode, cooling, setpoint
    wire [31:0] r_stat  = {13'h0000, mode_q, cool_q, sp_q};
    wire [31:0] r_data  = (ra == rsc_pkg::OFS_CTRL)   ? {29'h00000000, ctrl_q} :
                          (ra == rsc_pkg::OFS_BASE)   ? {16'h0000, base_q} :
                          (ra == rsc_pkg::OFS_OFFSET) ? {16'h0000, off_q} :
                          (ra == rsc_pkg::OFS_MODE)   ? {30'h00000000, mode_q} :
                          (ra == rsc_pkg::OFS_STATUS) ? r_stat :
                          r_cfg                       ? {16'h0000, cfg_arr[r_idx]} : 32'h00000000;


    logic [31:0] rdata_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h00000000;
        end else if (acc && !hwrite) begin
            rdata_q <= r_data;
        end
    end

    // read data held until the next read
    assign hrdata = rdata_q;

endmodule

/* File: rtl/rsc_pkg.sv */
// package of the room setpoint calculator
// assumes temperatures in signed 0.1 K steps, 16 bits
package rsc_pkg;

    // ------------------------------------------------------------
    // temperature format
    // ------------------------------------------------------------
    localparam int TW = 16;
    typedef logic signed [TW-1:0] rsc_temp_t;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_BASE      = 8'h04;
    localparam logic [7:0] OFS_OFFSET    = 8'h08;
    localparam logic [7:0] OFS_MODE      = 8'h0c;
    localparam logic [7:0] OFS_MAX_OFF   = 8'h10;
    localparam logic [7:0] OFS_BASE_MIN  = 8'h14;
    localparam logic [7:0] OFS_BASE_MAX  = 8'h18;
    localparam logic [7:0] OFS_STBY_RED  = 8'h1c;
    localparam logic [7:0] OFS_DEAD_ZONE = 8'h20;
    localparam logic [7:0] OFS_STBY_INC  = 8'h24;
    localparam logic [7:0] OFS_NIGHT_INC = 8'h28;
    localparam logic [7:0] OFS_FROST_SP  = 8'h2c;
    localparam logic [7:0] OFS_HEAT_SP   = 8'h30;
    localparam logic [7:0] OFS_STATUS    = 8'h34;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_ROT_OFFSET = 0;
    localparam int CTRL_HC_AUTO    = 1;
    localparam int CTRL_HC_COOL    = 2;
    localparam int STAT_COOL       = 16;
    localparam int STAT_MODE_LSB   = 17;

    // ------------------------------------------------------------
    // reset values, temperatures in 0.1 K steps
    // ------------------------------------------------------------
    localparam logic [2:0]  RST_CTRL      = 3'h3;
    localparam rsc_temp_t   RST_BASE      = 16'sh00d2;
    localparam rsc_temp_t   RST_MAX_OFF   = 16'sh0014;
    localparam rsc_temp_t   RST_BASE_MIN  = 16'sh0096;
    localparam rsc_temp_t   RST_BASE_MAX  = 16'sh0118;
    localparam rsc_temp_t   RST_STBY_RED  = 16'sh0014;
    localparam rsc_temp_t   RST_DEAD_ZONE = 16'sh0014;
    localparam rsc_temp_t   RST_STBY_INC  = 16'sh0014;
    localparam rsc_temp_t   RST_NIGHT_INC = 16'sh0028;
    localparam rsc_temp_t   RST_FROST_SP  = 16'sh0046;
    localparam rsc_temp_t   RST_HEAT_SP   = 16'sh015e;

    // ------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_COMFORT,
        MODE_STANDBY,
        MODE_NIGHT,
        MODE_PROTECT
    } rsc_mode_t;

    // configuration carried to the calculation
    typedef struct packed {
        rsc_temp_t max_off;
        rsc_temp_t base_min;
        rsc_temp_t base_max;
        rsc_temp_t stby_red;
        rsc_temp_t dead_zone;
        rsc_temp_t stby_inc;
        rsc_temp_t night_inc;
        rsc_temp_t frost_sp;
        rsc_temp_t heat_sp;
    } rsc_cfg_t;

    // local operator strobes with their values
    typedef struct packed {
        logic      rot_stb;
        rsc_temp_t rot_val;
        logic      mode_stb;
        rsc_mode_t mode_val;
    } rsc_local_t;

endpackage

/* File: verif/rsc_calc_monitor.sv */
// concurrent checks on the ports of the room setpoint calculator
// assumes one hclk domain and a single ahb-lite master with no wait states
`timescale 1ns/1ps
module rsc_calc_monitor (
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic                por_n,
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic [31:0]         hrdata,
    input wire rsc_pkg::rsc_local_t local_in,
    input wire logic                scene_stb,
    input wire rsc_pkg::rsc_mode_t  scene_mode,
    input wire logic                prog_stb,
    input wire rsc_pkg::rsc_mode_t  prog_mode,
    input wire rsc_pkg::rsc_temp_t  room_temp,
    input wire rsc_pkg::rsc_temp_t  setpoint,
    input wire logic                cooling,
    input wire rsc_pkg::rsc_mode_t  active_mode
);
    // ----------------------------------------
    // data phase and control shadow
    // ----------------------------------------
    logic       dph_q;
    logic       dwr_q;
    logic [7:0] dadr_q;
    logic [2:0] ctrl_q;
    logic [2:0] quiet_q;
    logic [1:0] wmode;
    logic       wr_mode;
    logic       quiet;
    assign wmode   = hwdata[1:0];
    assign wr_mode = dph_q && dwr_q && dadr_q == rsc_pkg::OFS_MODE;
    assign quiet   = por_n && !(hsel && htrans[1]) && !dph_q && !local_in.rot_stb && !local_in.mode_stb
                     && !scene_stb && !prog_stb;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_q   <= 1'b0;
            dwr_q   <= 1'b0;
            dadr_q  <= 8'h00;
            ctrl_q  <= rsc_pkg::RST_CTRL;
            quiet_q <= 3'h0;
        end else begin
            dph_q  <= hsel && htrans[1] && hready;
            dwr_q  <= hwrite;
            dadr_q <= haddr[7:0];
            if (dph_q && dwr_q && dadr_q == rsc_pkg::OFS_CTRL) begin
                ctrl_q <= hwdata[2:0];
            end
            quiet_q <= (!quiet || !$stable(room_temp)) ? 3'h0 : (quiet_q == 3'h7 ? quiet_q : quiet_q + 3'h1);
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd_status;
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] == rsc_pkg::OFS_STATUS ##1 1'b1;
    endsequence
    property p_okay; hreadyout && !hresp; endproperty
    property p_rst; $rose(hresetn) |-> setpoint == rsc_pkg::RST_BASE && !cooling && active_mode == 2'h0; endproperty
    property p_bus_mode; wr_mode |=> active_mode == $past(wmode); endproperty
    property p_local_mode; local_in.mode_stb && !wr_mode |=> active_mode == $past(local_in.mode_val); endproperty
    property p_prog_mode; prog_stb && !local_in.mode_stb && !wr_mode |=> active_mode == $past(prog_mode); endproperty
    property p_scene_mode;
        scene_stb && !prog_stb && !local_in.mode_stb && !wr_mode |=> active_mode == $past(scene_mode);
    endproperty
    property p_hold_mode;
        !scene_stb && !prog_stb && !local_in.mode_stb && !wr_mode |=> $stable(active_mode);
    endproperty
    property p_hc_manual; !ctrl_q[1] && $stable(ctrl_q) |-> cooling == ctrl_q[2]; endproperty
    property p_settled; quiet_q >= 3'h5 |-> $stable(setpoint) && $stable(cooling); endproperty
    property p_status;
        s_rd_status |-> hrdata == {13'h0, $past(active_mode), $past(cooling), $past(setpoint)};
    endproperty
    a_okay:       assert property (p_okay) else $error("bus answer not ready or not okay");
    a_rst:        assert property (p_rst) else $error("outputs wrong after reset");
    a_bus_mode:   assert property (p_bus_mode) else $error("mode write not taken");
    a_local_mode: assert property (p_local_mode) else $error("local mode not taken");
    a_prog_mode:  assert property (p_prog_mode) else $error("program mode not taken");
    a_scene_mode: assert property (p_scene_mode) else $error("scene mode not taken");
    a_hold_mode:  assert property (p_hold_mode) else $error("mode changed unasked");
    a_hc_manual:  assert property (p_hc_manual) else $error("cooling not per control");
    a_settled:    assert property (p_settled) else $error("setpoint drifts while quiet");
    a_status:     assert property (p_status) else $error("status read mismatch");
endmodule
bind rsc_calc rsc_calc_monitor rsc_calc_monitor_inst (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .local_in, .scene_stb, .scene_mode, .prog_stb, .prog_mode,
    .room_temp, .setpoint, .cooling, .active_mode);

/* File: verif/rsc_local_model.sv */
// local operator controls, program and scene sources
// assumes commands from the bench one cycle long; idle value lines toggle
`timescale 1ns/1ps
module rsc_local_model (
    input  wire logic               hclk,
    input  wire logic [2:0]         cmd,
    input  wire rsc_pkg::rsc_temp_t val,
    output rsc_pkg::rsc_local_t     local_o,
    output logic                    scene_stb,
    output rsc_pkg::rsc_mode_t      scene_mode,
    output logic                    prog_stb,
    output rsc_pkg::rsc_mode_t      prog_mode
);
    initial begin
        local_o    = '0;
        scene_stb  = 1'b0;
        scene_mode = rsc_pkg::MODE_COMFORT;
        prog_stb   = 1'b0;
        prog_mode  = rsc_pkg::MODE_COMFORT;
    end
    always @(posedge hclk) begin
        local_o.rot_stb  <= cmd == 3'h1;
        local_o.rot_val  <= cmd == 3'h1 ? val : ~local_o.rot_val;
        local_o.mode_stb <= cmd == 3'h2;
        local_o.mode_val <= cmd == 3'h2 ? rsc_pkg::rsc_mode_t'(val[1:0]) : rsc_pkg::rsc_mode_t'(~local_o.mode_val);
        prog_stb         <= cmd == 3'h3;
        prog_mode        <= cmd == 3'h3 ? rsc_pkg::rsc_mode_t'(val[1:0]) : rsc_pkg::rsc_mode_t'(~prog_mode);
        scene_stb        <= cmd == 3'h4;
        scene_mode       <= cmd == 3'h4 ? rsc_pkg::rsc_mode_t'(val[1:0]) : rsc_pkg::rsc_mode_t'(~scene_mode);
    end
endmodule

/* File: verif/room_setpoint_calculator_test.sv */
// self-checking bench of the room setpoint calculator
// assumes the one ahb-lite slave answers on hreadyout
`timescale 1ns/1ps
`define CK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module room_setpoint_calculator_test;
    typedef struct packed {logic [2:0] ctrl; logic [1:0] mode; logic [15:0] off; logic [15:0] sp; logic cool;} rsc_row_t;
    logic                hclk = 1'b0, hresetn = 1'b0, por_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0]         haddr = '0, hwdata = '0, hrdata, r;
    logic [1:0]          htrans = '0;
    logic [2:0]          cmd = '0;
    logic                hreadyout, hresp, cooling, scene_stb, prog_stb;
    rsc_pkg::rsc_temp_t  val = '0, room_temp = 16'sh00d7, setpoint;
    rsc_pkg::rsc_mode_t  scene_mode, prog_mode, active_mode;
    rsc_pkg::rsc_local_t local_in;
    int                  fails = 0, n_tests = 0, cyc = 0, i;
    rsc_pkg::rsc_temp_t  rv [9] = '{rsc_pkg::RST_MAX_OFF, rsc_pkg::RST_BASE_MIN, rsc_pkg::RST_BASE_MAX,
        rsc_pkg::RST_STBY_RED, rsc_pkg::RST_DEAD_ZONE, rsc_pkg::RST_STBY_INC, rsc_pkg::RST_NIGHT_INC,
        rsc_pkg::RST_FROST_SP, rsc_pkg::RST_HEAT_SP};
    // ctrl, mode, offset, setpoint, cooling; base 0x00d2
    rsc_row_t            rows [10] = '{'{3'h0, 2'h0, 16'h000a, 16'h00dc, 1'b0}, '{3'h0, 2'h1, 16'h000a, 16'h00c8, 1'b0},
        '{3'h0, 2'h2, 16'hfff6, 16'h00b4, 1'b0}, '{3'h0, 2'h3, 16'h000a, 16'h0046, 1'b0},
        '{3'h0, 2'h0, 16'h0032, 16'h00e6, 1'b0}, '{3'h0, 2'h0, 16'hffce, 16'h00be, 1'b0},
        '{3'h4, 2'h0, 16'hfff6, 16'h00dc, 1'b1}, '{3'h4, 2'h1, 16'hfff6, 16'h00f0, 1'b1},
        '{3'h4, 2'h2, 16'h0000, 16'h010e, 1'b1}, '{3'h4, 2'h3, 16'h0000, 16'h015e, 1'b1}};

    rsc_calc rsc_calc_inst (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .local_in, .scene_stb, .scene_mode, .prog_stb,
        .prog_mode, .room_temp, .setpoint, .cooling, .active_mode);
    rsc_local_model rsc_local_model_inst (.hclk, .cmd, .val, .local_o(local_in), .scene_stb, .scene_mode,
        .prog_stb, .prog_mode);

    initial forever #20 hclk = ~hclk;

    // ----------------------------------------
    // bus, wait and closing tasks
    // ----------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic send(input logic [2:0] c, input logic [15:0] v);
        cmd <= c;
        val <= v;
        tick(1);
        cmd <= 3'h0;
        tick(3);
    endtask
    task close_out;
        $display("checks %0d wrong %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            close_out;
        end
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        tick(12);
        hresetn <= 1'b1;
        por_n   <= 1'b1;
        tick(1);
        bus(0, 8'h34, 0); `CK("status", 32'h000000d2, r)
        bus(0, 8'h00, 0); `CK("ctrl", 32'h3, r)
        for (i = 0; i < 9; i++) begin
            bus(0, 8'h10 + 8'(4 * i), 0); `CK("reset reg", {16'h0, rv[i]}, r)
        end
        bus(0, 8'h3c, 0); `CK("unmapped", 32'h0, r)
        $display("test reset done");
        for (i = 0; i < 10; i++) begin
            bus(1, 8'h00, {29'h0, rows[i].ctrl});
            bus(1, 8'h08, {16'h0, rows[i].off});
            bus(1, 8'h0c, {30'h0, rows[i].mode});
            tick(3);
            bus(0, 8'h34, 0); `CK("status", {13'h0, rows[i].mode, rows[i].cool, rows[i].sp}, r)
        end
        $display("test table done");
        bus(1, 8'h00, 32'h1);
        bus(1, 8'h04, 32'h200);
        bus(0, 8'h04, 0); `CK("base high", 32'h118, r)
        bus(1, 8'h04, 32'h10);
        bus(0, 8'h04, 0); `CK("base low", 32'h96, r)
        bus(1, 8'h00, 32'h0);
        bus(1, 8'h04, 32'hc8);
        bus(0, 8'h04, 0); `CK("base locked", 32'h96, r)
        send(3'h1, 16'h00be);
        bus(0, 8'h04, 0); `CK("rotary base", 32'hbe, r)
        bus(1, 8'h00, 32'h1);
        bus(1, 8'h0c, 32'h0);
        send(3'h1, 16'h000a); `CK("rotary offset", 16'h00c8, setpoint)
        bus(1, 8'h08, 32'h14);
        tick(3); `CK("bus offset locked", 16'h00c8, setpoint)
        $display("test sources done");
        bus(1, 8'h00, 32'h4);
        bus(1, 8'h30, 32'hd2);
        tick(3); `CK("heat clamp", 16'h00d2, setpoint)
        send(3'h2, 16'h2); `CK("local mode", 2'h2, active_mode)
        send(3'h3, 16'h1); `CK("program mode", 2'h1, active_mode)
        send(3'h4, 16'h3); `CK("scene mode", 2'h3, active_mode)
        bus(1, 8'h00, 32'h2);
        room_temp <= 16'sh0190;
        tick(4); `CK("auto cool", 17'h100d2, {cooling, setpoint})
        room_temp <= 16'sh0064;
        tick(4); `CK("auto heat", 17'h00046, {cooling, setpoint})
        $display("test modes done");
        bus(1, 8'h00, 32'h1);
        bus(1, 8'h04, 32'h100);
        hresetn <= 1'b0;
        tick(2);
        hresetn <= 1'b1;
        tick(1);
        bus(0, 8'h04, 0); `CK("base kept", 32'h100, r)
        por_n <= 1'b0;
        tick(2);
        por_n <= 1'b1;
        tick(1);
        bus(0, 8'h04, 0); `CK("base power on", 32'hd2, r)
        $display("test reset kinds done");
        close_out;
    end
endmodule
